// >>> serial_regs.vh
`ifndef SERIAL_REGS_VH
`define SERIAL_REGS_VH
// ------------------------------
// register byte addresses
// ------------------------------
`define A_STAT 8'h00
`define A_DATA 8'h04
`define A_CR1 8'h08
`define A_CR2 8'h0c
`define A_BAUD 8'h10
// ------------------------------
// reset values
// ------------------------------
`define STAT_RST 8'hc0
`define BAUD_RST 16'h0036
// ------------------------------
// status bits
// ------------------------------
`define B_TXE 7
`define B_TXD 6
`define B_RXF 5
`define B_IDL 4
`define B_OVR 3
`define B_NSE 2
`define B_FRM 1
`define B_PAR 0
// ------------------------------
// control one bits
// ------------------------------
`define B_RX9 7
`define B_TX9 6
`define B_LPO 5
`define B_WLN 4
`define B_WAK 3
`define B_PEN 2
`define B_POD 1
`define B_PIE 0
// ------------------------------
// control two bits
// ------------------------------
`define B_TIE 7
`define B_TCI 6
`define B_RIE 5
`define B_ILI 4
`define B_TEN 3
`define B_REN 2
`define B_RWU 1
`define B_SBK 0
// ------------------------------
// sample indexes (number minus one)
// ------------------------------
`define SN3 4'h2
`define SN5 4'h4
`define SN7 4'h6
`define SN8 4'h7
`define SN9 4'h8
`define SN10 4'h9
`define SLAST 4'hf
// idle threshold in samples: frame bits times 16
`define IDLE8 8'ha0
`define IDLE9 8'hb0
`endif

// >>> async_serial_rx_status_ctrl.v
// The APB interface to the registers and the register addresses were left to the implementer.
`include "serial_regs.vh"
`default_nettype none
module async_serial_rx_status_ctrl #(
    parameter DIV_W = 16
) (
    input wire CLK,
    input wire RST_B,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    input wire RXD,
    output reg TXD,
    output reg IRQ,
    output reg WAKE,
    input wire IRQ_MASK,
    input wire HALT
);
// ------------------------------
// state
// ------------------------------
reg txe_q, txd_q, rxf_q, idl_q, ovr_q, nse_q, frm_q, par_q;
reg rx9_q, tx9_q, lpo_q, wln_q, wak_q, pen_q, pod_q, pie_q;
reg tie_q, tci_q, rie_q, ili_q, ten_q, ren_q, rwu_q, sbk_q;
reg [DIV_W-1:0] baud_q, div_q;
reg tick_q, seen_q, ten_d1_q, pre_q, idle_arm_q;
reg [7:0] thold_q, rhold_q, idle_cnt_q;
reg tx_busy_q, tx_dat_q;
reg [10:0] tx_sh_q;
reg [3:0] tx_bits_q, tx_sub_q;
reg rx_busy_q, rx_wln_q, rx_pen_q, rx_pod_q, rx_nse_q, s8_q, s9_q;
reg [3:0] rx_sub_q, rx_bit_q;
reg [8:0] rx_sh_q;
reg [2:0] hist_q;
reg [31:0] rdata;
// ------------------------------
// bus decode
// ------------------------------
wire setup = PSEL & ~PENABLE;
wire acc = PSEL & PENABLE & PREADY;
wire wr = acc & PWRITE;
wire rd = acc & ~PWRITE;
wire h_st = PADDR == `A_STAT;
wire h_da = PADDR == `A_DATA;
wire h_c1 = PADDR == `A_CR1;
wire h_c2 = PADDR == `A_CR2;
wire h_bd = PADDR == `A_BAUD;
wire mapped = h_st | h_da | h_c1 | h_c2 | h_bd;
// halt stops every bit-time event while the bus stays alive
wire t = tick_q & ~HALT;
wire run = ~HALT & ~(lpo_q & ~tx_busy_q & ~rx_busy_q);
// ------------------------------
// transmit frame build
// ------------------------------
wire [8:0] tw = {tx9_q, thold_q};
wire tp9 = ^thold_q ^ pod_q;
wire tp8 = ^thold_q[6:0] ^ pod_q;
reg [8:0] tword;
always @*
begin
    tword = tw;
    if (pen_q & wln_q)
    begin
        tword[8] = tp9;
    end
    else if (pen_q)
    begin
        tword[7] = tp8;
    end
end
wire [10:0] tframe = wln_q ? {1'b1, tword, 1'b0} : {2'b11, tword[7:0], 1'b0};
wire tx_go = t & ~tx_busy_q & ten_q & ~lpo_q;
wire tx_end = t & tx_busy_q & (tx_sub_q == `SLAST) & (tx_bits_q == 4'h1);
// ------------------------------
// receive sampling
// ------------------------------
wire maj = (s8_q & s9_q) | (s8_q & RXD) | (s9_q & RXD);
wire dis = ~((s8_q == s9_q) & (s9_q == RXD));
wire [3:0] last_bit = rx_wln_q ? 4'ha : 4'h9;
wire at10 = t & rx_busy_q & (rx_sub_q == `SN10);
wire stop_done = at10 & (rx_bit_q == last_bit);
wire [8:0] rword = rx_wln_q ? rx_sh_q : {1'b0, rx_sh_q[8:1]};
wire rpe = rx_pen_q & (^rword ^ rx_pod_q);
wire addr_mark = rx_sh_q[8];
wire [7:0] idle_thr = wln_q ? `IDLE9 : `IDLE8;
wire idle_hit = t & ~rx_busy_q & RXD & (idle_cnt_q == idle_thr - 8'h01);
// ------------------------------
// read mux
// ------------------------------
always @*
begin
    rdata = 32'h0;
    if (h_st)
    begin
        rdata[7:0] = {txe_q, txd_q, rxf_q, idl_q, ovr_q, nse_q, frm_q, par_q};
    end
    else if (h_da)
    begin
        rdata[7:0] = rhold_q;
    end
    else if (h_c1)
    begin
        rdata[7:0] = {rx9_q, tx9_q, lpo_q, wln_q, wak_q, pen_q, pod_q, pie_q};
    end
    else if (h_c2)
    begin
        rdata[7:0] = {tie_q, tci_q, rie_q, ili_q, ten_q, ren_q, rwu_q, sbk_q};
    end
    else if (h_bd)
    begin
        rdata[DIV_W-1:0] = baud_q;
    end
end
// ------------------------------
// interrupt request
// ------------------------------
wire irq_d = ((txe_q & tie_q) | (txd_q & tci_q)
    | ((rxf_q | ovr_q) & rie_q & ~rwu_q)
    | (idl_q & ili_q) | (par_q & pie_q)) & ~IRQ_MASK;
// ------------------------------
// registers
// ------------------------------
always @(posedge CLK or negedge RST_B)
begin
    if (!RST_B)
    begin
        PRDATA <= 32'h0;
        PREADY <= 1'b0;
        PSLVERR <= 1'b0;
        TXD <= 1'b1;
        IRQ <= 1'b0;
        WAKE <= 1'b0;
        {txe_q, txd_q, rxf_q, idl_q, ovr_q, nse_q, frm_q, par_q} <= `STAT_RST;
        {rx9_q, tx9_q, lpo_q, wln_q, wak_q, pen_q, pod_q, pie_q} <= 8'h00;
        {tie_q, tci_q, rie_q, ili_q, ten_q, ren_q, rwu_q, sbk_q} <= 8'h00;
        baud_q <= `BAUD_RST;
        div_q <= {DIV_W{1'b0}};
        tick_q <= 1'b0;
        seen_q <= 1'b0;
        ten_d1_q <= 1'b0;
        pre_q <= 1'b0;
        idle_arm_q <= 1'b1;
        thold_q <= 8'h00;
        rhold_q <= 8'h00;
        idle_cnt_q <= 8'h00;
        tx_busy_q <= 1'b0;
        tx_dat_q <= 1'b0;
        tx_sh_q <= 11'h7ff;
        tx_bits_q <= 4'h0;
        tx_sub_q <= 4'h0;
        rx_busy_q <= 1'b0;
        {rx_wln_q, rx_pen_q, rx_pod_q, rx_nse_q, s8_q, s9_q} <= 6'h00;
        rx_sub_q <= 4'h0;
        rx_bit_q <= 4'h0;
        rx_sh_q <= 9'h000;
        hist_q <= 3'h0;
    end
    else
    begin
        // bus slave: one wait-free access, read data captured in setup, write data in access
        PREADY <= setup;
        PSLVERR <= setup & ~mapped;
        PRDATA <= (setup & ~PWRITE) ? rdata : 32'h0;
        IRQ <= irq_d;
        WAKE <= irq_d & ~HALT;
        TXD <= tx_busy_q ? tx_sh_q[0] : 1'b1;
        // sample tick prescaler, frozen in halt, and in low power once transmitter and receiver are both idle
        if (run)
        begin
            div_q <= (div_q == {DIV_W{1'b0}}) ? baud_q : div_q - 1'b1;
        end
        tick_q <= run & (div_q == {DIV_W{1'b0}});
        // software side: clears come first so that hardware sets win
        if (acc & h_st)
        begin
            seen_q <= 1'b1;
        end
        if (acc & h_da)
        begin
            seen_q <= 1'b0;
            if (seen_q)
            begin
                par_q <= 1'b0;
            end
        end
        if (rd & h_da & seen_q)
        begin
            {rxf_q, idl_q, ovr_q, nse_q, frm_q} <= 5'h00;
        end
        if (wr & h_da)
        begin
            thold_q <= PWDATA[7:0];
            if (seen_q)
            begin
                txe_q <= 1'b0;
                txd_q <= 1'b0;
            end
        end
        if (wr & h_c1)
        begin
            {tx9_q, lpo_q, wln_q, wak_q, pen_q, pod_q, pie_q} <= PWDATA[6:0];
        end
        if (wr & h_c2)
        begin
            {tie_q, tci_q, rie_q, ili_q, ten_q, ren_q, rwu_q, sbk_q} <= PWDATA[7:0];
        end
        if (wr & h_bd)
        begin
            baud_q <= PWDATA[DIV_W-1:0];
        end
        // transmitter
        ten_d1_q <= ten_q;
        if (ten_q & ~ten_d1_q)
        begin
            pre_q <= 1'b1;
        end
        if (tx_go & sbk_q)
        begin
            tx_busy_q <= 1'b1;
            tx_dat_q <= 1'b0;
            tx_sh_q <= 11'h000;
            tx_bits_q <= wln_q ? 4'hb : 4'ha;
            tx_sub_q <= 4'h0;
        end
        else if (tx_go & pre_q)
        begin
            pre_q <= 1'b0;
            tx_busy_q <= 1'b1;
            tx_dat_q <= 1'b0;
            tx_sh_q <= 11'h7ff;
            tx_bits_q <= wln_q ? 4'hb : 4'ha;
            tx_sub_q <= 4'h0;
        end
        else if (tx_go & ~txe_q)
        begin
            // format sampled here, so control changes apply next byte
            txe_q <= 1'b1;
            tx_busy_q <= 1'b1;
            tx_dat_q <= 1'b1;
            tx_sh_q <= tframe;
            tx_bits_q <= wln_q ? 4'hb : 4'ha;
            tx_sub_q <= 4'h0;
        end
        else if (t & tx_busy_q)
        begin
            tx_sub_q <= tx_sub_q + 4'h1;
            if (tx_sub_q == `SLAST)
            begin
                tx_sh_q <= {1'b1, tx_sh_q[10:1]};
                tx_bits_q <= tx_bits_q - 4'h1;
            end
            if (tx_end)
            begin
                tx_busy_q <= 1'b0;
                if (tx_dat_q)
                begin
                    txd_q <= 1'b1;
                end
            end
        end
        // receiver: history of the line for start edge checks
        if (t)
        begin
            hist_q <= {hist_q[1:0], RXD};
        end
        if (t & ~rx_busy_q)
        begin
            idle_cnt_q <= ~RXD ? 8'h00 :
                (idle_cnt_q == idle_thr) ? idle_cnt_q : idle_cnt_q + 8'h01;
            if (ren_q & ~RXD & (hist_q == 3'h7))
            begin
                // latch format per frame; mid-frame changes are ignored
                rx_busy_q <= 1'b1;
                rx_sub_q <= 4'h1;
                rx_bit_q <= 4'h0;
                rx_wln_q <= wln_q;
                rx_pen_q <= pen_q;
                rx_pod_q <= pod_q;
            end
        end
        if (idle_hit)
        begin
            if (rwu_q & ~wak_q)
            begin
                rwu_q <= 1'b0;
            end
            else if (idle_arm_q & ~rwu_q)
            begin
                idl_q <= 1'b1;
                idle_arm_q <= 1'b0;
            end
        end
        if (t & rx_busy_q)
        begin
            rx_sub_q <= rx_sub_q + 4'h1;
            if (rx_sub_q == `SN8)
            begin
                s8_q <= RXD;
            end
            if (rx_sub_q == `SN9)
            begin
                s9_q <= RXD;
            end
            if (rx_sub_q == `SLAST)
            begin
                rx_bit_q <= rx_bit_q + 4'h1;
            end
            if ((rx_bit_q == 4'h0) & RXD &
                ((rx_sub_q == `SN3) | (rx_sub_q == `SN5) | (rx_sub_q == `SN7)))
            begin
                rx_nse_q <= 1'b1;
            end
        end
        if (at10)
        begin
            if (rx_bit_q == 4'h0)
            begin
                if (s8_q | s9_q | RXD)
                begin
                    rx_nse_q <= 1'b1;
                end
                // false start: drop frame, keep noise pending for next word
                if (maj)
                begin
                    rx_busy_q <= 1'b0;
                end
            end
            else
            begin
                if (dis)
                begin
                    rx_nse_q <= 1'b1;
                end
                if (~stop_done)
                begin
                    rx_sh_q <= {maj, rx_sh_q[8:1]};
                end
            end
        end
        if (stop_done)
        begin
            rx_busy_q <= 1'b0;
            if (~rwu_q | (wak_q & addr_mark))
            begin
                rx_nse_q <= 1'b0;
                if (rwu_q)
                begin
                    rwu_q <= 1'b0;
                end
                if (rxf_q)
                begin
                    ovr_q <= 1'b1;
                end
                else
                begin
                    rhold_q <= rword[7:0];
                    if (rx_wln_q)
                    begin
                        rx9_q <= rword[8];
                    end
                    rxf_q <= 1'b1;
                    idle_arm_q <= 1'b1;
                    nse_q <= rx_nse_q | dis;
                    frm_q <= ~maj;
                    par_q <= rpe;
                end
            end
        end
    end
end
endmodule // async_serial_rx_status_ctrl
`default_nettype wire

// >>> serial_status_sva.sv
`include "serial_regs.vh"
`default_nettype none
module serial_status_sva (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [31:0] PRDATA,
    input wire logic IRQ,
    input wire logic WAKE,
    input wire logic IRQ_MASK,
    input wire logic HALT
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------
    // bus and interrupt checks
    // ------------------------------
    wire logic acc = PSEL && PENABLE && PREADY;
    wire logic mapped = PADDR == `A_STAT || PADDR == `A_DATA || PADDR == `A_CR1
        || PADDR == `A_CR2 || PADDR == `A_BAUD;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    property p_ready; PSEL && !PENABLE |=> PREADY; endproperty
    a_ready: assert property (p_ready) else $error("no ready after setup");
    property p_ready_one; PREADY |=> !PREADY; endproperty
    a_ready_one: assert property (p_ready_one) else $error("ready held");
    property p_unmapped; acc && !mapped |-> PSLVERR && PRDATA == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
    property p_mapped; acc && mapped |-> !PSLVERR; endproperty
    a_mapped: assert property (p_mapped) else $error("mapped refused");
    property p_upper; acc && !PWRITE && PADDR != `A_BAUD |-> PRDATA[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_quiet; !PREADY |-> PRDATA == 32'h0; endproperty
    a_quiet: assert property (p_quiet) else $error("read data outside access");
    property p_mask; IRQ_MASK |=> !IRQ; endproperty
    a_mask: assert property (p_mask) else $error("irq while masked");
    property p_wake; WAKE == (IRQ && !$past(HALT)); endproperty
    a_wake: assert property (p_wake) else $error("wake wrong");
endmodule // serial_status_sva
bind async_serial_rx_status_ctrl serial_status_sva i_chk (.CLK(CLK), .RST_B(RST_B),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .PRDATA(PRDATA), .IRQ(IRQ), .WAKE(WAKE), .IRQ_MASK(IRQ_MASK),
    .HALT(HALT));
`default_nettype wire

// >>> serial_far_end.sv
`default_nettype none
module serial_far_end (
    input wire logic clk,
    output logic rxd,
    input wire logic txd
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------
    // remote line model, one tick per clock
    // ------------------------------
    initial rxd = 1'b1;
    task automatic send(input logic [7:0] b, input logic noisy);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
            for (int s = 1; s <= 16; s++)
            begin
                @(posedge clk);
                rxd <= (noisy && i == 1 && s == 9) ? ~f[i] : f[i];
            end
        // idle highs let the next start edge qualify
        repeat (4) @(posedge clk);
    endtask
    task automatic recv(output logic [7:0] b, output logic ok);
        ok = 1'b0;
        b = 8'h00;
        for (int n = 0; n < 4000 && !ok; n++)
        begin
            @(posedge clk);
            ok = txd === 1'b0;
        end
        repeat (8) @(posedge clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (16) @(posedge clk);
            b[i] = txd;
        end
    endtask
endmodule // serial_far_end
`default_nettype wire

// >>> testbench.sv
`include "serial_regs.vh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK = 0, RST_B = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, IRQ_MASK = 0, HALT = 0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    wire logic [31:0] PRDATA;
    wire logic PREADY, PSLVERR, RXD, TXD, IRQ, WAKE;
    int bad_count = 0, n_tests = 0;
    logic [31:0] r;
    logic e, ok;
    logic [7:0] b;
    always #5 CLK = ~CLK;
    async_serial_rx_status_ctrl i_dut (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .RXD(RXD), .TXD(TXD),
        .IRQ(IRQ), .WAKE(WAKE), .IRQ_MASK(IRQ_MASK), .HALT(HALT));
    serial_far_end i_far (.clk(CLK), .rxd(RXD), .txd(TXD));
    // ------------------------------
    // tasks
    // ------------------------------
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge CLK);
            if (PREADY === 1'b1)
                break;
        end
        r = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (n == 20)
        begin
            bad_count++;
            stop_test();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(r, exp);
    endtask
    // ------------------------------
    // sequence
    // ------------------------------
    initial
    begin
        repeat (8) @(posedge CLK);
        RST_B <= 1'b1;
        rd(`A_STAT, 32'hc0);
        rd(8'h14, 32'h0);
        chk(e, 1);
        apb(1'b1, `A_BAUD, 32'h0);
        // the divider still runs out its reset count; the line model needs a tick per clock
        repeat (64) @(posedge CLK);
        apb(1'b1, `A_CR2, 32'h2c);
        apb(1'b1, `A_STAT, 32'hff);
        i_far.send(8'ha5, 1'b0);
        chk(IRQ, 1);
        rd(`A_STAT, 32'he0);
        rd(`A_CR1, 32'h0);
        rd(`A_DATA, 32'ha5);
        rd(`A_STAT, 32'hc0);
        chk(IRQ, 0);
        i_far.send(8'h3c, 1'b1);
        rd(`A_STAT, 32'he4);
        rd(`A_DATA, 32'h3c);
        i_far.send(8'h11, 1'b0);
        i_far.send(8'h22, 1'b0);
        IRQ_MASK <= 1'b1;
        HALT <= 1'b1;
        repeat (2) @(posedge CLK);
        chk(IRQ, 0);
        chk(WAKE, 0);
        IRQ_MASK <= 1'b0;
        HALT <= 1'b0;
        rd(`A_STAT, 32'he8);
        chk(WAKE, 1);
        rd(`A_DATA, 32'h11);
        apb(1'b1, `A_CR1, 32'h05);
        i_far.send(8'h01, 1'b0);
        rd(`A_STAT, 32'he1);
        rd(`A_DATA, 32'h01);
        rd(`A_STAT, 32'hc0);
        apb(1'b1, `A_DATA, 32'h3c);
        rd(`A_STAT, 32'h80);
        i_far.recv(b, ok);
        chk(ok, 1);
        chk(b, 8'h3c);
        repeat (40) @(posedge CLK);
        rd(`A_STAT, 32'hd0);
        apb(1'b1, `A_CR2, 32'h8c);
        repeat (2) @(posedge CLK);
        chk(IRQ, 1);
        stop_test();
    end
endmodule // testbench
`default_nettype wire
